// [flash_pkg.sv]
// Shared constants for the serial flash erase, power-down and identification ends
// Overview of operation
// RQ1: D8h plus 24-bit address erases 64K block
// RQ2: Erases accepted only with write enable latch set
// RQ3: Block erase needs chip select rise after address
// RQ4: Block erase self-timed, busy high throughout
// RQ5: Block erase completion clears write enable latch
// RQ6: Protected block target skips block erase
// RQ7: C7h or 60h alone means chip erase
// RQ8: Chip erase after eighth bit, busy, clears latch
// RQ9: Any protection refuses chip erase entirely
// RQ10: B9h then chip select rise enters power-down
// RQ11: Powered down, only ABh is recognised
// RQ12: Device starts in normal operation after reset
// RQ13: ABh alone releases after first release delay
// RQ14: ABh plus three dummies shifts device ID
// RQ15: Device ID repeats until chip select rises
// RQ16: ID read from power-down uses second delay
// RQ17: ABh ignored while busy
// RQ18: 90h address zero sends maker then device
// RQ19: Address one swaps order; bytes keep alternating
// RQ20: Input bits sampled on serial clock rise
// RQ21: Erase without latch leaves busy untouched
package flash_pkg;
	localparam int CLK_MHZ = 200;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_RELEASE_ID = 8'hab;
	localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
	localparam logic [5:0] OPCODE_BITS = 6'd8;
	localparam logic [5:0] HEADER_BITS = 6'd32;
	localparam logic [5:0] COUNT_SATURATE = 6'd40;
	// Times in their own units; counts derived below
	localparam int BLOCK_ERASE_TIME_US = 1000;
	localparam int CHIP_ERASE_TIME_US = 10000;
	localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
	localparam int RELEASE_DELAY_PLAIN_NS = 3000;
	localparam int RELEASE_DELAY_ID_NS = 1800;
	localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
	localparam int POWER_DOWN_ENTRY_CYCLES = POWER_DOWN_ENTRY_TIME_NS * CLK_MHZ / 1000;
	localparam int RELEASE_PLAIN_CYCLES = RELEASE_DELAY_PLAIN_NS * CLK_MHZ / 1000;
	localparam int RELEASE_ID_CYCLES = RELEASE_DELAY_ID_NS * CLK_MHZ / 1000;
	// Host keeps chip select high at least this long after each command
	localparam int HOST_GAP_CYCLES = RELEASE_PLAIN_CYCLES + 8;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS * CLK_MHZ / 2000;
	localparam int BLOCK_COUNT = 16;
	// Arbitrary identity values, not any real part's
	localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5a;
	localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h23;
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_ERASE = 2'b01,
		T_ENTER = 2'b11,
		T_RELEASE = 2'b10
	} timer_mode_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_GAP = 2'b11
	} host_state_t;
endpackage

// [flash_if.sv]
// Serial link between host controller and flash device
`timescale 1ns/100ps
interface flash_if;
	logic cs_n;
	logic sclk;
	logic serial_in_io;
	logic so_d;
	logic so_oe;
	logic so;
	// Output line pulled high while the device does not drive it
	assign so = so_oe ? so_d : 1'b1;
	modport device (input cs_n, input sclk, input serial_in_io, output so_d, output so_oe);
	modport host (output cs_n, output sclk, output serial_in_io, input so);
endinterface

// [flash_dev.sv]
// Flash device end: erase, power-down and identification command handling
`timescale 1ns/100ps
module flash_dev #(
	parameter int unsigned BLOCK_ERASE_CYC = flash_pkg::BLOCK_ERASE_CYCLES,
	parameter int unsigned CHIP_ERASE_CYC = flash_pkg::CHIP_ERASE_CYCLES,
	parameter logic [7:0] MAKER_ID = flash_pkg::MAKER_ID_DEFAULT,
	parameter logic [7:0] DEVICE_ID = flash_pkg::DEVICE_ID_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst,
	flash_if.device link,
	input wire logic write_enable_set,
	input wire logic top_bottom_select,
	input wire logic protect_range_bit2,
	input wire logic protect_range_bit1,
	input wire logic protect_range_bit0,
	output logic busy,
	output logic write_enable_latch,
	output logic powered_down,
	output logic erase_start,
	output logic erase_chip,
	output logic [7:0] erase_block
);
	import flash_pkg::*;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic ck_s1;
		logic ck_s2;
		logic ck_s3;
		logic si_s1;
		logic si_s2;
		logic [5:0] cnt;
		logic [31:0] shift;
		logic [7:0] op;
		logic [23:0] addr;
		logic [2:0] out_idx;
		logic out_sel;
		logic out_on;
		logic so;
		timer_mode_t mode;
		logic [31:0] timer;
		logic we_latch;
		logic pd;
		logic start;
		logic chip;
		logic [7:0] blk;
	} dev_state_t;

	dev_state_t q, d;
	logic [2:0] bp;
	logic ck_rise, ck_fall, cs_rise, cs_fall, done, id_active;
	logic [7:0] cur_byte;

	function automatic logic block_protected(input logic [2:0] bpv, input logic at_bottom,
		input logic [7:0] blk);
		logic [8:0] n;
		n = (bpv == 3'd0) ? 9'd0 : (9'd1 << (bpv - 3'd1));
		if (bpv == 3'd7 || n >= 9'(BLOCK_COUNT))
			return 1'b1;
		if (at_bottom)
			return {1'b0, blk} < n;
		return {1'b0, blk} >= 9'(BLOCK_COUNT) - n;
	endfunction

	assign bp = {protect_range_bit2, protect_range_bit1, protect_range_bit0};
	assign ck_rise = q.ck_s2 & ~q.ck_s3;
	assign ck_fall = ~q.ck_s2 & q.ck_s3;
	assign cs_rise = q.cs_s2 & ~q.cs_s3;
	assign cs_fall = ~q.cs_s2 & q.cs_s3;
	assign done = (q.mode != T_IDLE) && (q.timer == 32'h0);
	// Erase and power-down entry silence all identification output; power-down itself silences only 90h
	assign id_active = (q.mode != T_ERASE) && (q.mode != T_ENTER) && (
		(q.op == OP_RELEASE_ID) ||
		(q.op == OP_MAKER_DEVICE_ID && !q.pd && q.addr[23:1] == 23'h0)); // see RQ17, RQ11
	// Address bit zero picks which byte leads; out_sel flips after every byte
	assign cur_byte = (q.op == OP_RELEASE_ID || (q.out_sel ^ q.addr[0])) ? DEVICE_ID
		: MAKER_ID; // see RQ18, RQ19

	always_comb begin
		d = q;
		d.cs_s1 = link.cs_n;
		d.cs_s2 = q.cs_s1;
		d.cs_s3 = q.cs_s2;
		d.ck_s1 = link.sclk;
		d.ck_s2 = q.ck_s1;
		d.ck_s3 = q.ck_s2;
		d.si_s1 = link.serial_in_io;
		d.si_s2 = q.si_s1;
		d.start = 1'b0;
		if (q.timer != 32'h0)
			d.timer = q.timer - 32'h1;
		if (write_enable_set && !q.pd)
			d.we_latch = 1'b1;
		if (cs_fall) begin
			d.cnt = 6'd0;
			d.out_idx = 3'd0;
			d.out_sel = 1'b0;
			d.out_on = 1'b0;
		end else if (!q.cs_s2 && ck_rise) begin
			d.shift = {q.shift[30:0], q.si_s2}; // see RQ20
			if (q.cnt != COUNT_SATURATE)
				d.cnt = q.cnt + 6'd1;
			if (q.cnt == OPCODE_BITS - 6'd1)
				d.op = {q.shift[6:0], q.si_s2};
			if (q.cnt == HEADER_BITS - 6'd1)
				d.addr = {q.shift[22:0], q.si_s2};
		end else if (!q.cs_s2 && ck_fall && q.cnt >= HEADER_BITS && id_active) begin
			// Bits leave on the falling edge, most significant first
			d.out_on = 1'b1;
			d.so = cur_byte[3'd7 - q.out_idx]; // see RQ14, RQ18
			d.out_idx = q.out_idx + 3'd1;
			if (q.out_idx == 3'd7)
				d.out_sel = ~q.out_sel; // see RQ15, RQ19
		end
		if (cs_rise) begin
			d.out_on = 1'b0; // see RQ15
			if (q.mode == T_IDLE && q.pd) begin
				// Only release is heard while powered down
				if (q.op == OP_RELEASE_ID && q.cnt == OPCODE_BITS) begin // see RQ11
					d.mode = T_RELEASE;
					d.timer = 32'(RELEASE_PLAIN_CYCLES - 1); // see RQ13
				end else if (q.op == OP_RELEASE_ID && q.cnt >= HEADER_BITS) begin
					d.mode = T_RELEASE;
					d.timer = 32'(RELEASE_ID_CYCLES - 1); // see RQ16
				end
			end else if (q.mode == T_IDLE) begin
				if (q.cnt == OPCODE_BITS) begin // see RQ3, RQ8, RQ10
					if ((q.op == OP_CHIP_ERASE_A || q.op == OP_CHIP_ERASE_B) && q.we_latch
						&& bp == 3'd0) begin // see RQ7, RQ9, RQ2, RQ21
						d.mode = T_ERASE;
						d.timer = CHIP_ERASE_CYC - 32'h1; // see RQ8
						d.start = 1'b1;
						d.chip = 1'b1;
					end else if (q.op == OP_POWER_DOWN) begin
						d.mode = T_ENTER;
						d.timer = 32'(POWER_DOWN_ENTRY_CYCLES - 1); // see RQ10
					end
				end else if (q.cnt == HEADER_BITS && q.op == OP_BLOCK_ERASE && q.we_latch
					&& !block_protected(bp, top_bottom_select, q.addr[23:16])) begin
					// see RQ1, RQ2, RQ3, RQ6, RQ21
					d.mode = T_ERASE;
					d.timer = BLOCK_ERASE_CYC - 32'h1; // see RQ4
					d.start = 1'b1;
					d.chip = 1'b0;
					d.blk = q.addr[23:16];
				end
			end
		end
		if (done) begin
			d.mode = T_IDLE;
			unique case (q.mode)
				T_ERASE: begin
					// Set wins when a write enable lands on the finishing cycle
					d.we_latch = write_enable_set; // see RQ5, RQ8
				end
				T_ENTER: d.pd = 1'b1;
				T_RELEASE: d.pd = 1'b0;
				default: d.mode = T_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0; // see RQ12
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_s3 <= 1'b1;
			q.mode <= T_IDLE;
		end else begin
			q <= d;
		end
	end

	assign link.so_d = q.so;
	assign link.so_oe = q.out_on & ~q.cs_s2;
	assign busy = (q.mode == T_ERASE); // see RQ4
	assign write_enable_latch = q.we_latch;
	assign powered_down = q.pd;
	assign erase_start = q.start;
	assign erase_chip = q.chip;
	assign erase_block = q.blk;
endmodule

// [flash_host.sv]
// Host end: serial controller issuing one command frame per request
`timescale 1ns/100ps
module flash_host (
	input wire logic mclk,
	input wire logic rst,
	flash_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic cmd_has_addr,
	input wire logic [7:0] cmd_read_bytes,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	import flash_pkg::*;

	typedef struct packed {
		host_state_t st;
		logic [7:0] div;
		logic sclk;
		logic cs_n;
		logic [31:0] tx;
		logic [11:0] done_bits;
		logic [11:0] hdr_bits;
		logic [11:0] total_bits;
		logic [7:0] rx;
		logic [7:0] rd;
		logic rdv;
		logic [15:0] gap;
		logic so_s1;
		logic so_s2;
	} host_reg_t;

	host_reg_t q, d;
	logic tick;
	logic [7:0] rx_next;

	assign tick = (q.div == 8'(SCLK_HALF_CYCLES - 1));
	assign rx_next = {q.rx[6:0], q.so_s2};
	assign cmd_ready = (q.st == H_IDLE);

	always_comb begin
		d = q;
		d.so_s1 = link.so;
		d.so_s2 = q.so_s1;
		d.rdv = 1'b0;
		unique case (q.st)
			H_IDLE: begin
				if (cmd_valid) begin
					d.st = H_SHIFT;
					d.cs_n = 1'b0;
					d.div = 8'h0;
					d.done_bits = 12'h0;
					d.tx = cmd_has_addr ? {cmd_op, cmd_addr} : {cmd_op, 24'h0};
					d.hdr_bits = cmd_has_addr ? 12'd32 : 12'd8;
					d.total_bits = (cmd_has_addr ? 12'd32 : 12'd8) + {1'b0, cmd_read_bytes, 3'b0};
				end
			end
			H_SHIFT: begin
				d.div = tick ? 8'h0 : q.div + 8'h1;
				if (tick && !q.sclk) begin
					d.sclk = 1'b1;
					d.rx = rx_next;
					d.done_bits = q.done_bits + 12'h1;
					if (q.done_bits >= q.hdr_bits && q.done_bits[2:0] == 3'd7) begin
						d.rd = rx_next;
						d.rdv = 1'b1;
					end
				end else if (tick) begin
					d.sclk = 1'b0;
					d.tx = {q.tx[30:0], 1'b0};
					if (q.done_bits == q.total_bits) begin
						// Raise select right after the last latched bit
						d.cs_n = 1'b1; // see RQ3, RQ8, RQ10
						d.st = H_GAP;
						d.gap = 16'h0;
					end
				end
			end
			H_GAP: begin
				// Select stays high long enough for either release delay
				d.gap = q.gap + 16'h1; // see RQ13, RQ16
				if (q.gap == 16'(HOST_GAP_CYCLES - 1))
					d.st = H_IDLE;
			end
			default: d.st = H_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.cs_n <= 1'b1;
			q.so_s1 <= 1'b1;
			q.so_s2 <= 1'b1;
			q.st <= H_IDLE;
		end else begin
			q <= d;
		end
	end

	assign link.cs_n = q.cs_n;
	assign link.sclk = q.sclk;
	assign link.serial_in_io = q.tx[31];
	assign rd_data = q.rd;
	assign rd_valid = q.rdv;
endmodule

// [flash_link_chk.sv]
// Assertions on the serial link between host and flash device
`timescale 1ns/100ps
module flash_link_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in_io,
	input wire logic so_d,
	input wire logic so_oe,
	input wire logic so
);
	logic sclk_q;
	logic [5:0] rises_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Clock rises in the current frame; saturates so a runaway frame cannot wrap
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			rises_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				rises_q <= 6'h00;
			else if (sclk && !sclk_q && rises_q != 6'h3f)
				rises_q <= rises_q + 6'h01;
		end
	end
	a_released_high: assert property (!so_oe |-> so)
		else $error("output line low while released");
	a_oe_after_cs: assert property ($rose(cs_n) |-> ##[0:3] !so_oe)
		else $error("output driven after chip select rise");
	a_clock_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock moves outside a frame");
	a_clock_high_hold: assert property ($rose(sclk) |=> $stable(sclk)[*8])
		else $error("serial clock high phase too short");
	a_data_steady: assert property (sclk && $past(sclk) |-> $stable(serial_in_io))
		else $error("input data changed while clock high");
	a_output_on_low: assert property (so_oe && $changed(so_d) |-> !sclk)
		else $error("output bit changed while clock high");
	a_frame_whole_bytes: assert property ($rose(cs_n) |-> rises_q >= 6'h08 && rises_q[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
	a_id_after_header: assert property (so_oe && !cs_n |-> rises_q >= 6'h20)
		else $error("output driven before header complete");
	c_id_read: cover property ($rose(so_oe));
	c_long_frame: cover property ($rose(cs_n) && rises_q == 6'h20);
	c_short_frame: cover property ($rose(cs_n) && rises_q == 6'h08);
endmodule

// [serial_flash_erase_power_id_tb.sv]
// Bench joining the host and device ends over the serial link
`timescale 1ns/100ps
module serial_flash_erase_power_id_tb;
	import flash_pkg::*;
	localparam logic [7:0] mk = MAKER_ID_DEFAULT;
	localparam logic [7:0] dv = DEVICE_ID_DEFAULT;
	// Flags f: has address, write enable pulse, top_bottom_select, latch expected after
	typedef struct {logic [7:0] op; logic [23:0] a; logic [3:0] f; logic [2:0] bp;
		logic [7:0] n; logic [23:0] eb; logic [23:0] bz; logic [23:0] rd;} row_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_op = 8'h00;
	logic [23:0] cmd_addr = 24'h0;
	logic cmd_has_addr = 1'b0;
	logic [7:0] cmd_read_bytes = 8'h00;
	logic write_enable_set = 1'b0;
	logic top_bottom_select = 1'b0;
	logic [2:0] bp = 3'h0;
	logic cmd_ready, rd_valid, busy, write_enable_latch, powered_down, erase_start, erase_chip;
	logic [7:0] rd_data, erase_block;
	logic [23:0] starts = 24'h0;
	logic [23:0] busy_n = 24'h0;
	int err_count = 0;
	int comparisons = 0;
	int k, i, j;
	logic [7:0] rdq[$];
	row_t rows[12];
	flash_if lk();
	flash_dev #(.BLOCK_ERASE_CYC(2000), .CHIP_ERASE_CYC(400)) flash_dev_inst (.mclk, .rst,
		.link(lk.device), .write_enable_set, .top_bottom_select, .protect_range_bit2(bp[2]),
		.protect_range_bit1(bp[1]), .protect_range_bit0(bp[0]), .busy, .write_enable_latch,
		.powered_down, .erase_start, .erase_chip, .erase_block);
	flash_host flash_host_inst (.mclk, .rst, .link(lk.host), .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_addr, .cmd_has_addr, .cmd_read_bytes, .rd_data, .rd_valid);
	flash_link_chk flash_link_chk_inst (.mclk, .rst, .cs_n(lk.cs_n), .sclk(lk.sclk),
		.serial_in_io(lk.serial_in_io), .so_d(lk.so_d), .so_oe(lk.so_oe), .so(lk.so));
	initial forever #2.5 mclk = ~mclk;
	// Pre-edge values are read here, so the order against the design does not matter
	always @(posedge mclk) begin
		if (erase_start === 1'b1)
			starts++;
		if (busy === 1'b1)
			busy_n++;
		if (rd_valid === 1'b1)
			rdq.push_back(rd_data);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic go(input logic [7:0] op, input logic [23:0] a, input logic h, input logic [7:0] n);
		cmd_op = op;
		cmd_addr = a;
		cmd_has_addr = h;
		cmd_read_bytes = n;
		cmd_valid = 1'b1;
		for (k = 0; k < 100 && cmd_ready !== 1'b1; k++)
			@(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	// Host does not see device busy, so the bench waits on it when b is set
	task automatic fin(input logic b);
		for (k = 0; k < 9000 && (cmd_ready !== 1'b1 || (b && busy !== 1'b0)); k++)
			@(negedge mclk);
		repeat (8) @(negedge mclk);
	endtask
	task automatic wen;
		write_enable_set = 1'b1;
		@(negedge mclk);
		write_enable_set = 1'b0;
	endtask
	task automatic rel(input logic h, input logic [7:0] n, input logic mid);
		go(OP_RELEASE_ID, 24'h0, h, n);
		@(posedge lk.cs_n);
		repeat (200) @(negedge mclk);
		check(powered_down, 1'b1);
		repeat (200) @(negedge mclk);
		check(powered_down, mid);
		fin(1'b1);
		check(powered_down, 1'b0);
	endtask
	initial begin
		rows = '{'{8'hd8, 24'h030000, 4'h8, 3'h0, 8'h00, 24'h0, 24'h0, 24'h0},
			'{8'hd8, 24'h030000, 4'hc, 3'h0, 8'h00, 24'h003, 24'h7d0, 24'h0},
			'{8'hc7, 24'h0, 4'h4, 3'h0, 8'h00, 24'h103, 24'h190, 24'h0},
			'{8'h60, 24'h0, 4'h4, 3'h0, 8'h00, 24'h103, 24'h190, 24'h0},
			'{8'hc7, 24'h0, 4'h5, 3'h1, 8'h00, 24'h0, 24'h0, 24'h0},
			'{8'hd8, 24'h0f0000, 4'hd, 3'h1, 8'h00, 24'h0, 24'h0, 24'h0},
			'{8'hd8, 24'h0f0000, 4'he, 3'h1, 8'h00, 24'h00f, 24'h7d0, 24'h0},
			'{8'hd8, 24'h0, 4'h5, 3'h0, 8'h00, 24'h0, 24'h0, 24'h0},
			'{8'hb9, 24'h0, 4'h9, 3'h0, 8'h00, 24'h0, 24'h0, 24'h0},
			'{8'h90, 24'h0, 4'h9, 3'h0, 8'h02, 24'h0, 24'h0, {mk, dv, 8'h00}},
			'{8'h90, 24'h000001, 4'h9, 3'h0, 8'h03, 24'h0, 24'h0, {dv, mk, dv}},
			'{8'hab, 24'h0, 4'h9, 3'h0, 8'h02, 24'h0, 24'h0, {dv, dv, 8'h00}}};
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		for (i = 0; i < 12; i++) begin
			{bp, top_bottom_select} = {rows[i].bp, rows[i].f[1]};
			if (rows[i].f[2])
				wen();
			{starts, busy_n} = 48'h0;
			rdq.delete();
			go(rows[i].op, rows[i].a, rows[i].f[3], rows[i].n);
			fin(1'b1);
			check(starts, rows[i].bz != 24'h0);
			check({busy_n, write_enable_latch, powered_down}, {rows[i].bz, rows[i].f[0], 1'b0});
			if (rows[i].bz != 24'h0)
				check({erase_chip, erase_block}, rows[i].eb);
			for (j = 0; j < rows[i].n; j++)
				check(rdq[j], rows[i].rd[23 - 8 * j -: 8]);
		end
		wen();
		{starts, busy_n} = 48'h0;
		rdq.delete();
		go(OP_BLOCK_ERASE, 24'h030000, 1'b1, 8'h00);
		fin(1'b0);
		go(OP_RELEASE_ID, 24'h0, 1'b1, 8'h01);
		fin(1'b1);
		check({rdq[0], busy_n}, {8'hff, 24'h7d0});
		go(OP_POWER_DOWN, 24'h0, 1'b0, 8'h00);
		fin(1'b1);
		wen();
		starts = 24'h0;
		rdq.delete();
		go(OP_BLOCK_ERASE, 24'h0, 1'b1, 8'h00);
		fin(1'b1);
		go(OP_MAKER_DEVICE_ID, 24'h0, 1'b1, 8'h01);
		fin(1'b1);
		check(powered_down, 1'b1);
		check({starts, rdq[0]}, {24'h0, 8'hff});
		rel(1'b0, 8'h00, 1'b1);
		go(OP_POWER_DOWN, 24'h0, 1'b0, 8'h00);
		fin(1'b1);
		rdq.delete();
		rel(1'b1, 8'h01, 1'b0);
		check(rdq[0], dv);
		go(OP_POWER_DOWN, 24'h0, 1'b0, 8'h00);
		fin(1'b1);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		check({powered_down, busy, write_enable_latch, lk.cs_n}, 4'h1);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		results();
	end
	// Whole sequence needs about 35000 cycles
	initial begin
		repeat (80000) @(posedge mclk);
		err_count++;
		results();
	end
endmodule
